// *** include/wdt_cfg.svh ***
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ============================================================
// special function register addresses
`define WDT_ADDR_CTRL 8'hA7
`define WDT_ADDR_RELOAD 8'hC1
`define WDT_ADDR_FEED1 8'hC2
`define WDT_ADDR_FEED2 8'hC3

// ============================================================
// feed values
`define WDT_FEED1_VAL 8'hA5
`define WDT_FEED2_VAL 8'h5A

// ============================================================
// control register layout and reset values
`define WDT_BIT_CLKSEL 0
`define WDT_BIT_FLAG 1
`define WDT_BIT_RUN 2
`define WDT_PRE_LSB 5
`define WDT_PRE_MSB 7
`define WDT_CTRL_RST 8'hE5
`define WDT_RELOAD_RST 8'hFF

// ============================================================
// prescaler: first tap is 2^5, full width 13 bits
`define WDT_PRESC_W 13
`define WDT_TAP_MASK_MAX 13'h0FFF
`define WDT_PRE_MAX 3'h7

// ============================================================
// clock rates
`define WDT_CLK_HZ 20000000
`define WDT_OSC_HZ 400000
`define WDT_PCLK_DIV 2

`endif

// *** include/wdt_pkg.sv ***
package wdt_pkg;

    // watchdog clock sources
    typedef enum logic [1:0] {
        wdt_src_pclk,
        wdt_src_osc,
        wdt_src_xtal
    } wdt_src_type;

    // clock switch synchroniser states
    typedef enum logic [1:0] {
        wdt_sync_run,
        wdt_sync_desel,
        wdt_sync_sel
    } wdt_sync_state_type;

endpackage : wdt_pkg

// *** core/wdt_clk_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module wdt_clk_sync
    import wdt_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // source ticks
    input wire logic pclk_tick_i,
    input wire logic osc_tick_i,
    input wire logic xtal_tick_i,
    // requested source
    input wire wdt_src_type sel_i,
    // selected tick
    output logic tick_o,
    output logic busy_o
);

    wdt_sync_state_type state_q, state_d;
    wdt_src_type cur_q, cur_d;
    wdt_src_type new_q, new_d;
    logic cnt_q, cnt_d;
    logic old_t;
    logic new_t;

    function automatic logic pick(input wdt_src_type s, input logic p,
                                  input logic o, input logic x);
        logic r;
        r = 1'b0;
        case (s)
            wdt_src_pclk: r = p;
            wdt_src_osc: r = o;
            wdt_src_xtal: r = x;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : pick

    // ============================================================
    // deselect old source, then select new one
    always_comb begin
        state_d = state_q;
        cur_d = cur_q;
        new_d = new_q;
        cnt_d = cnt_q;
        old_t = pick(cur_q, pclk_tick_i, osc_tick_i, xtal_tick_i);
        new_t = pick(new_q, pclk_tick_i, osc_tick_i, xtal_tick_i);
        unique case (state_q)
            wdt_sync_run: begin
                if (sel_i != cur_q) begin
                    state_d = wdt_sync_desel;
                    new_d = sel_i;
                    cnt_d = 1'b0;
                end
            end
            // a stopped old clock holds the switch here indefinitely
            wdt_sync_desel: begin
                if (old_t) begin // RULE_12 RULE_15
                    if (cnt_q) begin
                        state_d = wdt_sync_sel;
                        cnt_d = 1'b0;
                    end else begin
                        cnt_d = 1'b1;
                    end
                end
            end
            wdt_sync_sel: begin
                if (new_t) begin // RULE_12
                    if (cnt_q) begin
                        state_d = wdt_sync_run;
                        cur_d = new_q;
                        cnt_d = 1'b0;
                    end else begin
                        cnt_d = 1'b1;
                    end
                end
            end
        endcase
        tick_o = (state_q == wdt_sync_run) && old_t;
        busy_o = (state_q != wdt_sync_run);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= wdt_sync_run;
            cur_q <= wdt_src_osc;
            new_q <= wdt_src_osc;
            cnt_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cur_q <= cur_d;
            new_q <= new_d;
            cnt_q <= cnt_d;
        end
    end

endmodule : wdt_clk_sync

`default_nettype wire

// *** core/wdt_watchdog.sv ***
// Summary of operation
// RULE_01 - timeout is 2^(5+tap)*(reload+1)+1 ticks
// RULE_02 - control resets E5h, flag by reset cause
// RULE_03 - select bit: 1 oscillator, 0 peripheral clock
// RULE_04 - power-down stops peripheral clock counting
// RULE_05 - both enables force oscillator select
// RULE_06 - counter underflow sets timeout flag
// RULE_07 - flag cleared by feed or writing 0; a feed clears it in watchdog mode only
// RULE_08 - run bit gates counting, forced by enables
// RULE_09 - crystal select overrides clock select bit
// RULE_10 - built-in 400 KHz oscillator tick
// RULE_11 - clock selection loads only at feed
// RULE_12 - switch: two old, then two new ticks
// RULE_13 - prescaler restarts right after feed
// RULE_14 - software keeps old clock two cycles
// RULE_15 - stopped old clock blocks oscillator select
// RULE_16 - software feeds before underflow when enabled
// RULE_17 - 13-bit prescaler tap drives 8-bit counter
// RULE_18 - feed is A5h then 5Ah, no writes between
// RULE_19 - control and reload load at feed end
// RULE_20 - timer mode reloads, flags, interrupts, ignores
// RULE_21 - flag reads 1 after watchdog reset
`include "wdt_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module wdt_watchdog
    import wdt_pkg::*;
#(
    parameter int OSC_DIV = `WDT_CLK_HZ / `WDT_OSC_HZ,
    parameter int PCLK_DIV = `WDT_PCLK_DIV
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // special function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // configuration and system state
    input wire logic reset_enable_i,
    input wire logic safety_enable_i,
    input wire logic crystal_select_i,
    input wire logic irq_enable_i,
    input wire logic powerdown_i,
    input wire logic wdt_cause_i,
    // crystal oscillator pin
    input wire logic xtal_clk_i,
    // events
    output logic wdt_reset_o,
    output logic wdt_irq_o,
    output logic timeout_flag_o
);

    // ============================================================
    // elaboration checks
    generate
        if (OSC_DIV < 2 || OSC_DIV > 256) begin : g_bad_osc
            $error("OSC_DIV must lie in 2..256");
        end
        if (PCLK_DIV < 1 || PCLK_DIV > 16) begin : g_bad_pclk
            $error("PCLK_DIV must lie in 1..16");
        end
    endgenerate

    localparam logic [7:0] OSC_LAST = 8'(OSC_DIV - 1);
    localparam logic [3:0] PCLK_LAST = 4'(PCLK_DIV - 1);

    // ============================================================
    // reset release
    logic rst_s1_q;
    logic rst_n;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // ============================================================
    // state
    logic [7:0] osc_cnt_q, osc_cnt_d;
    logic [3:0] pclk_cnt_q, pclk_cnt_d;
    logic xt_s1_q, xt_s2_q, xt_s3_q;
    logic osc_tick, pclk_tick, xtal_tick;
    logic wd_tick;

    logic [7:0] sfr_ctrl_q, sfr_ctrl_d;
    logic [7:0] reload_q, reload_d;
    logic [2:0] act_pre_q, act_pre_d;
    logic act_run_q, act_run_d;
    wdt_src_type act_src_q, act_src_d;
    logic [`WDT_PRESC_W-1:0] presc_q, presc_d;
    logic [7:0] count_q, count_d;
    logic expired_q, expired_d;
    logic flag_q, flag_d;
    logic init_q, init_d;
    logic armed_q, armed_d;
    logic pend_q, pend_d;
    logic rst_out_q, rst_out_d;
    logic irq_q, irq_d;
    logic [7:0] rdata_q, rdata_d;

    // decoded helpers
    logic wd_mode, forced, run_eff, clksel_eff;
    logic wr_ctrl, wr_reload, wr_feed1, wr_feed2;
    logic feed1_ok, feed_done, bad_feed, underflow;
    logic [`WDT_PRESC_W-1:0] tap_mask;
    wdt_src_type src_req;

    // ============================================================
    // crystal pin synchroniser, edge taken after the second stage
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            xt_s1_q <= 1'b0;
            xt_s2_q <= 1'b0;
            xt_s3_q <= 1'b0;
        end else begin
            xt_s1_q <= xtal_clk_i;
            xt_s2_q <= xt_s1_q;
            xt_s3_q <= xt_s2_q;
        end
    end

    // ============================================================
    // clock source ticks
    always_comb begin
        osc_tick = (osc_cnt_q == OSC_LAST); // RULE_10
        osc_cnt_d = osc_tick ? 8'h00 : osc_cnt_q + 8'h01;
        // peripheral clock is frozen in power-down
        pclk_tick = !powerdown_i && (pclk_cnt_q == PCLK_LAST); // RULE_04
        if (powerdown_i) begin
            pclk_cnt_d = pclk_cnt_q;
        end else if (pclk_tick) begin
            pclk_cnt_d = 4'h0;
        end else begin
            pclk_cnt_d = pclk_cnt_q + 4'h1;
        end
        xtal_tick = xt_s2_q && !xt_s3_q;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_q <= 8'h00;
            pclk_cnt_q <= 4'h0;
        end else begin
            osc_cnt_q <= osc_cnt_d;
            pclk_cnt_q <= pclk_cnt_d;
        end
    end

    wdt_clk_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .pclk_tick_i(pclk_tick),
        .osc_tick_i(osc_tick),
        .xtal_tick_i(xtal_tick),
        .sel_i(act_src_q),
        .tick_o(wd_tick),
        .busy_o()
    );

    // ============================================================
    // register decode and feed checking
    always_comb begin
        wd_mode = reset_enable_i;
        forced = reset_enable_i && safety_enable_i;
        run_eff = sfr_ctrl_q[`WDT_BIT_RUN] || forced; // RULE_08
        clksel_eff = sfr_ctrl_q[`WDT_BIT_CLKSEL] || forced; // RULE_05
        if (crystal_select_i) begin
            src_req = wdt_src_xtal; // RULE_09
        end else if (clksel_eff) begin
            src_req = wdt_src_osc; // RULE_03
        end else begin
            src_req = wdt_src_pclk;
        end
        wr_ctrl = sfr_wr_i && (sfr_addr_i == `WDT_ADDR_CTRL);
        wr_reload = sfr_wr_i && (sfr_addr_i == `WDT_ADDR_RELOAD);
        wr_feed1 = sfr_wr_i && (sfr_addr_i == `WDT_ADDR_FEED1);
        wr_feed2 = sfr_wr_i && (sfr_addr_i == `WDT_ADDR_FEED2);
        feed1_ok = wr_feed1 && (sfr_wdata_i == `WDT_FEED1_VAL);
        feed_done = wr_feed2 && armed_q
            && (sfr_wdata_i == `WDT_FEED2_VAL); // RULE_18
        // any write breaking the pair, or a control write left unfed
        bad_feed = (wr_feed1 && !feed1_ok)
            || (wr_feed2 && !feed_done)
            || (sfr_wr_i && armed_q && !wr_feed2)
            || (sfr_wr_i && pend_q && !feed1_ok); // RULE_18
        tap_mask = `WDT_TAP_MASK_MAX >> (`WDT_PRE_MAX - act_pre_q); // RULE_17
        underflow = wd_tick && act_run_q && expired_q;
    end

    // ============================================================
    // next state of the timer and its registers
    always_comb begin
        sfr_ctrl_d = sfr_ctrl_q;
        reload_d = reload_q;
        act_pre_d = act_pre_q;
        act_run_d = act_run_q;
        act_src_d = act_src_q;
        presc_d = presc_q;
        count_d = count_q;
        expired_d = expired_q;
        flag_d = flag_q;
        init_d = 1'b1;
        armed_d = armed_q;
        pend_d = pend_q;
        rst_out_d = 1'b0;
        irq_d = 1'b0;

        if (wr_ctrl) begin
            sfr_ctrl_d = sfr_wdata_i;
            pend_d = wd_mode;
        end else if (sfr_wr_i) begin
            pend_d = 1'b0;
        end
        if (wr_reload) begin
            reload_d = sfr_wdata_i;
        end
        if (sfr_wr_i) begin
            armed_d = feed1_ok;
        end

        // timer mode follows the control prescaler and run bits every watchdog tick
        if (!wd_mode && wd_tick) begin
            act_pre_d = sfr_ctrl_q[`WDT_PRE_MSB:`WDT_PRE_LSB];
            act_run_d = run_eff;
        end

        // ---- counting
        if (wd_tick && act_run_q) begin // RULE_08
            if (expired_q) begin
                expired_d = 1'b0; // RULE_01
                presc_d = '0;
                if (wd_mode) begin
                    rst_out_d = 1'b1; // RULE_17
                end else begin
                    count_d = reload_q; // RULE_20
                    irq_d = irq_enable_i; // RULE_20
                end
            end else if (presc_q == tap_mask) begin
                presc_d = '0;
                if (count_q == 8'h00) begin
                    expired_d = 1'b1; // RULE_01
                end else begin
                    count_d = count_q - 8'h01; // RULE_17
                end
            end else begin
                presc_d = presc_q + `WDT_PRESC_W'(1);
            end
        end

        // ---- feed completion
        if (feed_done) begin
            act_pre_d = sfr_ctrl_q[`WDT_PRE_MSB:`WDT_PRE_LSB]; // RULE_19
            act_run_d = run_eff; // RULE_19
            act_src_d = src_req; // RULE_11
            count_d = reload_q; // RULE_19
            presc_d = '0; // RULE_13
            expired_d = 1'b0;
        end
        if (bad_feed && wd_mode) begin
            rst_out_d = 1'b1; // RULE_18
        end

        // ---- timeout flag, setting beats clearing
        if (wr_ctrl && !sfr_wdata_i[`WDT_BIT_FLAG]) begin
            flag_d = 1'b0; // RULE_07
        end
        if (feed_done && wd_mode) begin
            flag_d = 1'b0; // RULE_07
        end
        if (underflow) begin
            flag_d = 1'b1; // RULE_06
        end
        // reset cause is taken once, in the first cycle after release
        if (!init_q) begin
            flag_d = wdt_cause_i; // RULE_21 RULE_02
        end
    end

    // ============================================================
    // read data, control bits 4:3 read as zero
    always_comb begin
        if (sfr_addr_i == `WDT_ADDR_CTRL) begin
            rdata_d = {sfr_ctrl_q[`WDT_PRE_MSB:`WDT_PRE_LSB], 2'b00,
                       run_eff, flag_q, clksel_eff};
        end else if (sfr_addr_i == `WDT_ADDR_RELOAD) begin
            rdata_d = reload_q;
        end else begin
            rdata_d = 8'h00;
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sfr_ctrl_q <= `WDT_CTRL_RST; // RULE_02
            reload_q <= `WDT_RELOAD_RST;
            act_pre_q <= `WDT_PRE_MAX;
            act_run_q <= 1'b1;
            act_src_q <= wdt_src_osc;
            presc_q <= '0;
            count_q <= `WDT_RELOAD_RST;
            expired_q <= 1'b0;
            flag_q <= 1'b0;
            init_q <= 1'b0;
            armed_q <= 1'b0;
            pend_q <= 1'b0;
            rst_out_q <= 1'b0;
            irq_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            sfr_ctrl_q <= sfr_ctrl_d;
            reload_q <= reload_d;
            act_pre_q <= act_pre_d;
            act_run_q <= act_run_d;
            act_src_q <= act_src_d;
            presc_q <= presc_d;
            count_q <= count_d;
            expired_q <= expired_d;
            flag_q <= flag_d;
            init_q <= init_d;
            armed_q <= armed_d;
            pend_q <= pend_d;
            rst_out_q <= rst_out_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata_o = rdata_q;
    assign wdt_reset_o = rst_out_q;
    assign wdt_irq_o = irq_q;
    assign timeout_flag_o = flag_q;

endmodule : wdt_watchdog

`default_nettype wire

// *** testbench/wdt_watchdog_checker.sv ***
`timescale 1ns/10ps
`default_nettype none

module wdt_watchdog_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    // modes and events
    input wire logic reset_enable_i,
    input wire logic safety_enable_i,
    input wire logic irq_enable_i,
    input wire logic wdt_reset_o,
    input wire logic wdt_irq_o,
    input wire logic timeout_flag_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // ============================================================
    // feed, reset and interrupt pulses
    a_bad_feed2: assert property (sfr_wr_i && reset_enable_i &&
        sfr_addr_i == 8'hC3 && sfr_wdata_i != 8'h5A |=> wdt_reset_o)
        else $error("bad second feed gave no reset");
    a_reset_mode: assert property (wdt_reset_o |-> $past(reset_enable_i))
        else $error("reset pulse in timer mode");
    a_reset_pulse: assert property (wdt_reset_o |=> !wdt_reset_o)
        else $error("reset pulse longer than one cycle");
    a_irq_pulse: assert property (wdt_irq_o |=> !wdt_irq_o)
        else $error("interrupt pulse longer than one cycle");
    a_irq_cause: assert property (wdt_irq_o |-> $past(irq_enable_i) &&
        !$past(reset_enable_i) && timeout_flag_o)
        else $error("interrupt without enable or flag");

    // ============================================================
    // control register and unmapped reads
    a_flag_clear: assert property (sfr_wr_i && sfr_addr_i == 8'hA7 &&
        !sfr_wdata_i[1] |=> !timeout_flag_o || wdt_irq_o || wdt_reset_o)
        else $error("flag not cleared by write of zero");
    a_rsvd_zero: assert property ($past(sfr_addr_i) == 8'hA7 |->
        sfr_rdata_o[4:3] == 2'b00)
        else $error("reserved control bits read nonzero");
    a_unmapped_zero: assert property (!($past(sfr_addr_i) inside
        {8'hA7, 8'hC1, 8'hC2, 8'hC3}) |-> sfr_rdata_o == 8'h00)
        else $error("unmapped address read nonzero");
    a_safety_force: assert property ($past(reset_enable_i &&
        safety_enable_i && sfr_addr_i == 8'hA7) |->
        sfr_rdata_o[2] && sfr_rdata_o[0])
        else $error("safety mode did not force run and select");
endmodule : wdt_watchdog_checker

bind wdt_watchdog wdt_watchdog_checker u_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .reset_enable_i(reset_enable_i),
    .safety_enable_i(safety_enable_i), .irq_enable_i(irq_enable_i),
    .wdt_reset_o(wdt_reset_o), .wdt_irq_o(wdt_irq_o),
    .timeout_flag_o(timeout_flag_o)
);

`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb;
    // ============================================================
    // signals
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic reset_enable_i = 1'b1;
    logic safety_enable_i = 1'b0;
    logic crystal_select_i = 1'b0;
    logic irq_enable_i = 1'b1;
    logic powerdown_i = 1'b0;
    logic wdt_cause_i = 1'b0;
    logic xtal_clk_i = 1'b0;
    logic [7:0] sfr_rdata_o;
    logic wdt_reset_o, wdt_irq_o, timeout_flag_o;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    int k;

    always #25 clk_i = ~clk_i;
    // crystal near 7 clk periods, phase unrelated to clk_i
    // even half period never lands on a rising clock edge
    always #172 xtal_clk_i = ~xtal_clk_i;

    wdt_watchdog #(.OSC_DIV(2), .PCLK_DIV(2)) u_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .reset_enable_i(reset_enable_i),
        .safety_enable_i(safety_enable_i),
        .crystal_select_i(crystal_select_i), .irq_enable_i(irq_enable_i),
        .powerdown_i(powerdown_i), .wdt_cause_i(wdt_cause_i),
        .xtal_clk_i(xtal_clk_i), .wdt_reset_o(wdt_reset_o),
        .wdt_irq_o(wdt_irq_o), .timeout_flag_o(timeout_flag_o)
    );

    // ============================================================
    // helpers
    task automatic wrap_up();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        sfr_wr_i = 1'b0;
        repeat (n) @(posedge clk_i);
        #2;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        // strobe stays up until the next tick, so back-to-back
        // writes never drop and raise it in one time step
        @(posedge clk_i);
        #2;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr_i = a;
        tick(1);
        check(sfr_rdata_o, exp);
    endtask : rd

    task automatic feed();
        wr(8'hC2, 8'hA5);
        wr(8'hC3, 8'h5A);
    endtask : feed

    task automatic prog(input logic [7:0] ctrl, input logic [7:0] rl);
        wr(8'hC1, rl);
        wr(8'hA7, ctrl);
        feed();
    endtask : prog

    // k ends as cycles waited, or max + 1 when no pulse came
    task automatic wait_ev(input logic irq, input int max);
        k = 0;
        while (k <= max && (irq ? wdt_irq_o : wdt_reset_o) !== 1'b1) begin
            tick(1);
            k++;
        end
    endtask : wait_ev

    task automatic span(input int lo, input int hi);
        check({7'h00, k >= lo && k <= hi}, 8'h01);
    endtask : span

    task automatic do_reset(input logic cause);
        nrst_i = 1'b0;
        wdt_cause_i = cause;
        tick(5);
        nrst_i = 1'b1;
        tick(4);
    endtask : do_reset

    task automatic flag_is(input logic v);
        check({7'h00, timeout_flag_o}, {7'h00, v});
    endtask : flag_is

    // ============================================================
    // scenarios
    task automatic t_regs();
        do_reset(1'b0);
        rd(8'hA7, 8'hE5);
        rd(8'hC1, 8'hFF);
        rd(8'hA0, 8'h00);
        do_reset(1'b1);
        rd(8'hA7, 8'hE7);
        flag_is(1'b1);
        do_reset(1'b0);
    endtask : t_regs

    task automatic t_timeouts();
        int e;
        for (int t = 0; t < 3; t++) begin
            for (int r = 0; r < 4; r += 3) begin
                e = 2 * ((2 ** (5 + t)) * (r + 1) + 1);
                prog({t[2:0], 5'h05}, r[7:0]);
                wr(8'hC1, 8'hFF);
                wait_ev(1'b0, e + 10);
                span(e - 3, e + 4);
                tick(1);
                flag_is(1'b1);
                feed();
                tick(1);
                flag_is(1'b0);
            end
        end
    endtask : t_timeouts

    task automatic t_bad();
        logic [7:0] sq [4][4] = '{'{8'hC2, 8'hA5, 8'hC1, 8'h00},
            '{8'hC1, 8'h00, 8'hC3, 8'h5A}, '{8'hC2, 8'hA5, 8'hC3, 8'h55},
            '{8'hA7, 8'hE5, 8'hC1, 8'hFF}};
        prog(8'hE5, 8'hFF);
        wr(8'hC2, 8'hA5);
        rd(8'hA7, 8'hE5);
        wr(8'hC3, 8'h5A);
        wait_ev(1'b0, 20);
        span(21, 21);
        for (int i = 0; i < 4; i++) begin
            wr(sq[i][0], sq[i][1]);
            wr(sq[i][2], sq[i][3]);
            wait_ev(1'b0, 3);
            span(0, 2);
            feed();
        end
    endtask : t_bad

    task automatic t_timer();
        reset_enable_i = 1'b0;
        prog(8'h05, 8'h00);
        wait_ev(1'b1, 80);
        span(63, 70);
        flag_is(1'b1);
        wr(8'hC3, 8'h00);
        wait_ev(1'b0, 10);
        span(11, 11);
        wait_ev(1'b1, 80);
        span(40, 70);
        wr(8'hA7, 8'h01);
        tick(1);
        flag_is(1'b0);
        wait_ev(1'b1, 300);
        span(301, 301);
        irq_enable_i = 1'b0;
        wr(8'hA7, 8'h05);
        wait_ev(1'b1, 150);
        span(151, 151);
        flag_is(1'b1);
        wr(8'hA7, 8'h01);
        irq_enable_i = 1'b1;
        reset_enable_i = 1'b1;
    endtask : t_timer

    task automatic t_safety();
        safety_enable_i = 1'b1;
        prog(8'h00, 8'h00);
        rd(8'hA7, 8'h05);
        wait_ev(1'b0, 80);
        span(62, 70);
        safety_enable_i = 1'b0;
    endtask : t_safety

    task automatic t_pdown();
        prog(8'h04, 8'h00);
        powerdown_i = 1'b1;
        rd(8'hA7, 8'h04);
        wait_ev(1'b0, 400);
        span(401, 401);
        powerdown_i = 1'b0;
        wait_ev(1'b0, 90);
        span(1, 90);
    endtask : t_pdown

    task automatic t_xtal();
        prog(8'h04, 8'h00);
        crystal_select_i = 1'b1;
        wait_ev(1'b0, 80);
        span(63, 70);
        prog(8'h05, 8'h00);
        wait_ev(1'b0, 300);
        span(210, 265);
        crystal_select_i = 1'b0;
    endtask : t_xtal

    // ============================================================
    // main sequence and hang limit
    initial begin
        t_regs();
        t_timeouts();
        t_bad();
        t_timer();
        t_safety();
        t_pdown();
        t_xtal();
        wrap_up();
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
endmodule : tb

`default_nettype wire
